/* File: scps_port.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Transmit buffer
// ----------------------------------------------------------------
module scps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clocking.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("scps_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH]; // Storage words.
    logic [AW:0] wr_ptr_r; // Write pointer with wrap bit.
    logic [AW:0] rd_ptr_r; // Read pointer with wrap bit.

    // Full when pointers differ only in the wrap bit.
    assign in_ready = (wr_ptr_r != {~rd_ptr_r[AW], rd_ptr_r[AW-1:0]});
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data = mem_r[rd_ptr_r[AW-1:0]];

    // Write side.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
        end else if (clk_en && in_valid && in_ready) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // Read side.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_ptr_r <= '0;
        end else if (clk_en && out_valid && out_ready) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule

// Functional notes
// - Card clock generated; bit ratio 372, down to 16.
// - Card clock 50% duty, 0.01 to 25 MHz; the 40 MHz clock clamps it at 20 MHz.
// - Data timing independent of card clock edges.
// - Six pins per port; instantiate twice.
// - Device starts session, card answers with reset answer.
// - Supply first, then clock start marks T0.
// - Reset low 40000 clocks; card silent meanwhile.
// - Reset stays high; answer 400..40000 after T1.
// - Deactivate: reset, clock, data, supply, in order.
// - Each deactivation step takes one slow period.
// - Deactivate on removal or software command.
// - Reset falls at the first slow clock rise after removal.
module scps_port
    import scps_pkg::*;
#(
    parameter int ATR_MAX = ATR_MAX_CLKS,
    parameter int RST_LOW = RST_LOW_CLKS,
    parameter int FIFO_DEPTH = 16
) (
    // Clocking and control.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Software controls.
    input wire logic activate_req,
    input wire logic deactivate_req,
    input wire logic low_reset_card,
    input wire logic [15:0] clk_half_cycles,
    input wire logic [15:0] clks_per_bit,
    input wire logic flags_clr,
    // Software status.
    output logic session_active,
    output logic seq_busy,
    output logic answer_timeout,
    output logic answer_early,
    output logic removal_flag,
    // Transmit stream into the buffer.
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // Receive stream.
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_parity_err,
    // Card pins.
    output logic card_clock_out,
    output logic card_reset_line,
    output logic card_supply_enable,
    input wire logic card_io_in,
    output logic card_io_out,
    output logic card_io_oe_n,
    input wire logic card_presence_detect,
    input wire logic slow_reference_clock
);
    // The counter serves both intervals, so it saturates just past the longer one.
    localparam int CNT_TOP = (ATR_MAX > RST_LOW) ? ATR_MAX : RST_LOW;
    localparam int CNT_W = $clog2(CNT_TOP + 2);
    localparam logic [CNT_W-1:0] CNT_TOP_C = CNT_W'(CNT_TOP);
    localparam logic [CNT_W-1:0] ATR_MIN_C = CNT_W'(ATR_MIN_CLKS);
    localparam logic [CNT_W-1:0] ATR_MAX_C = CNT_W'(ATR_MAX);
    localparam logic [CNT_W-1:0] RST_LOW_C = CNT_W'(RST_LOW);

    if (ATR_MAX <= ATR_MIN_CLKS || RST_LOW < 1 || FIFO_DEPTH < 2) begin : g_chk
        $error("scps_port parameters out of range");
    end

    // ----------------------------------------------------------------
    // Helper: clamp a programmed count into its legal range
    // ----------------------------------------------------------------
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] async_in; // Io, presence, slow clock, all from outside.
    logic [2:0] sync1_r; // First stage, read only by the second.
    logic [2:0] sync2_r; // Second stage, safe to use.
    logic [2:0] sync3_r; // Delayed copy for edge detection.

    // All pins are mutually asynchronous, so each gets its own pair.
    assign async_in = {slow_reference_clock, card_presence_detect, card_io_in};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                sync1_r[i] <= 1'b1;
                sync2_r[i] <= 1'b1;
                sync3_r[i] <= 1'b1;
            end else if (clk_en) begin
                sync1_r[i] <= async_in[i];
                sync2_r[i] <= sync1_r[i];
                sync3_r[i] <= sync2_r[i];
            end
        end
    end

    logic io_fall; // Start bit edge on the data line.
    logic pd_fall; // Card removed.
    logic ck_rise; // Slow reference clock period boundary.
    assign io_fall = sync3_r[0] && !sync2_r[0];
    assign pd_fall = sync3_r[1] && !sync2_r[1];
    assign ck_rise = !sync3_r[2] && sync2_r[2];

    // ----------------------------------------------------------------
    // Card clock divider
    // ----------------------------------------------------------------
    scps_state_e state_r; // Sequencer state.
    logic clk_run_r; // Card clock is allowed to toggle.
    logic [15:0] div_cnt_r; // Half period counter.
    logic [15:0] half_sel; // Clamped half period.
    logic div_hit; // Half period elapsed.
    logic clk_rise; // Card clock about to rise.

    // The 40 MHz clock tops out at 20 MHz card clock; faster settings clamp.
    assign half_sel = clamp16(clk_half_cycles, 16'(HALF_MIN_CYC), 16'(HALF_MAX_CYC));
    assign div_hit = clk_run_r && (div_cnt_r >= half_sel - 16'h0001);
    assign clk_rise = div_hit && !card_clock_out;

    // Equal high and low halves give the 50 percent duty cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_cnt_r <= 16'h0000;
            card_clock_out <= 1'b0;
        end else if (clk_en) begin
            if (!clk_run_r) begin
                div_cnt_r <= 16'h0000;
                card_clock_out <= 1'b0;
            end else if (div_hit) begin
                div_cnt_r <= 16'h0000;
                card_clock_out <= !card_clock_out;
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Activation and deactivation sequencer
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cyc_cnt_r; // Card clocks since T0 or T1.
    logic [1:0] step_r; // Deactivation step.
    logic deact_go; // Begin deactivation.
    logic in_window; // Waiting for the reset answer.

    assign in_window = (state_r == SCPS_ANS);
    assign deact_go = (pd_fall || deactivate_req) && state_r != SCPS_OFF
                      && state_r != SCPS_DEACT;

    // Card clock cycle count, restarted at T0 and at T1.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cyc_cnt_r <= '0;
        end else if (clk_en) begin
            if (state_r == SCPS_PWR || (state_r == SCPS_RSTLO && cyc_cnt_r >= RST_LOW_C)) begin
                cyc_cnt_r <= '0;
            end else if (clk_rise && cyc_cnt_r <= CNT_TOP_C) begin
                cyc_cnt_r <= cyc_cnt_r + 1'b1;
            end
        end
    end

    // Main sequence: supply, clock, optional reset pulse, answer, session.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= SCPS_OFF;
            step_r <= 2'h0;
            clk_run_r <= 1'b0;
            card_reset_line <= 1'b0;
            card_supply_enable <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                SCPS_OFF: begin
                    // An absent card is never powered.
                    if (activate_req && sync2_r[1]) begin
                        card_supply_enable <= 1'b1;
                        state_r <= SCPS_PWR;
                    end
                end
                SCPS_PWR: begin
                    // Supply is already up; starting the clock now is T0.
                    clk_run_r <= 1'b1;
                    card_reset_line <= !low_reset_card;
                    // A removal in this single cycle must not be lost.
                    if (deact_go) begin
                        state_r <= SCPS_DEACT;
                    end else begin
                        state_r <= low_reset_card ? SCPS_RSTLO : SCPS_ANS;
                    end
                end
                SCPS_RSTLO: begin
                    if (deact_go) begin
                        state_r <= SCPS_DEACT;
                    end else if (cyc_cnt_r >= RST_LOW_C) begin
                        card_reset_line <= 1'b1;
                        state_r <= SCPS_ANS;
                    end
                end
                SCPS_ANS: begin
                    if (deact_go) begin
                        state_r <= SCPS_DEACT;
                    end else if (io_fall) begin
                        state_r <= SCPS_SESS;
                    end
                end
                SCPS_SESS: begin
                    // Reset line stays high for the whole session.
                    if (deact_go) begin
                        state_r <= SCPS_DEACT;
                    end
                end
                SCPS_DEACT: begin
                    // One step per slow clock period, in fixed order.
                    if (ck_rise) begin
                        step_r <= step_r + 2'h1;
                        case (step_r)
                            2'h0: card_reset_line <= 1'b0;
                            2'h1: clk_run_r <= 1'b0;
                            2'h2: card_supply_enable <= 1'b1;
                            default: begin
                                card_supply_enable <= 1'b0;
                                state_r <= SCPS_OFF;
                            end
                        endcase
                    end
                end
                default: state_r <= SCPS_OFF;
            endcase
        end
    end

    assign session_active = (state_r == SCPS_SESS);
    assign seq_busy = (state_r != SCPS_OFF) && (state_r != SCPS_SESS);

    // ----------------------------------------------------------------
    // Status flags; a new event wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            answer_timeout <= 1'b0;
            answer_early <= 1'b0;
            removal_flag <= 1'b0;
        end else if (clk_en) begin
            if (in_window && cyc_cnt_r > ATR_MAX_C) begin
                answer_timeout <= 1'b1;
            end else if (flags_clr) begin
                answer_timeout <= 1'b0;
            end
            // Answer too soon, or any start bit while reset is held low.
            if (io_fall && (state_r == SCPS_RSTLO
                            || (in_window && cyc_cnt_r < ATR_MIN_C))) begin
                answer_early <= 1'b1;
            end else if (flags_clr) begin
                answer_early <= 1'b0;
            end
            if (pd_fall) begin
                removal_flag <= 1'b1;
            end else if (flags_clr) begin
                removal_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Character engine: half duplex, timed in card clocks
    // ----------------------------------------------------------------
    logic [15:0] ratio_sel; // Clamped card clocks per bit.
    logic [15:0] etu_cnt_r; // Card clocks left in the current bit.
    logic [3:0] bit_idx_r; // Bit position in the character.
    logic rx_busy_r; // Receiving a character.
    logic tx_busy_r; // Sending a character.
    logic [11:0] tx_sh_r; // Outgoing bits, start first.
    logic [8:0] rx_sh_r; // Incoming data and parity.
    logic fifo_valid; // Buffer holds a character.
    logic [7:0] fifo_data; // Next character to send.
    logic tx_take; // Buffer word accepted by the engine.
    logic bit_end; // Current bit time complete.

    assign ratio_sel = clamp16(clks_per_bit, 16'(RATIO_MIN), 16'hffff);
    assign bit_end = clk_rise && (etu_cnt_r == 16'h0001);
    // The engine stalls the buffer until the line is free in a session.
    // A starting deactivation must not pop a word that will never be sent.
    assign tx_take = fifo_valid && session_active && !rx_busy_r && !tx_busy_r && !io_fall
                     && !deact_go;

    scps_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_txbuf (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(tx_take),
        .out_data(fifo_data)
    );

    // Bit timing: sample mid bit on receive, whole bits on transmit.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            etu_cnt_r <= 16'h0000;
            bit_idx_r <= 4'h0;
            rx_busy_r <= 1'b0;
            tx_busy_r <= 1'b0;
            tx_sh_r <= 12'hfff;
            rx_sh_r <= 9'h000;
        end else if (clk_en) begin
            if (deact_go || state_r == SCPS_DEACT) begin
                rx_busy_r <= 1'b0;
                tx_busy_r <= 1'b0;
                tx_sh_r <= 12'hfff;
            end else if (tx_take) begin
                tx_busy_r <= 1'b1;
                bit_idx_r <= 4'h0;
                etu_cnt_r <= ratio_sel;
                // Guard, guard, even parity, data LSB first, start.
                tx_sh_r <= {2'b11, ^fifo_data, fifo_data, 1'b0};
            end else if (!rx_busy_r && !tx_busy_r && io_fall
                         && (in_window || session_active)) begin
                // Bit timing comes from the start edge, not the card clock phase.
                rx_busy_r <= 1'b1;
                bit_idx_r <= 4'h0;
                etu_cnt_r <= {1'b0, ratio_sel[15:1]};
            end else if (clk_rise && (rx_busy_r || tx_busy_r)) begin
                if (bit_end) begin
                    etu_cnt_r <= ratio_sel;
                    bit_idx_r <= bit_idx_r + 4'h1;
                    if (tx_busy_r) begin
                        tx_sh_r <= {1'b1, tx_sh_r[11:1]};
                        tx_busy_r <= (bit_idx_r != TX_LAST_BIT);
                    end else begin
                        rx_sh_r <= {sync2_r[0], rx_sh_r[8:1]};
                        // A start bit gone high is a glitch; drop it.
                        rx_busy_r <= (bit_idx_r != RX_LAST_BIT)
                                     && !(bit_idx_r == 4'h0 && sync2_r[0]);
                    end
                end else begin
                    etu_cnt_r <= etu_cnt_r - 16'h0001;
                end
            end
        end
    end

    // Received character out, with its parity check.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_parity_err <= 1'b0;
        end else if (clk_en) begin
            rx_valid <= 1'b0;
            if (rx_busy_r && bit_end && bit_idx_r == RX_LAST_BIT) begin
                rx_valid <= 1'b1;
                rx_data <= rx_sh_r[8:1];
                rx_parity_err <= ^{sync2_r[0], rx_sh_r[8:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Data line driver: open drain, enable low while pulling down
    // ----------------------------------------------------------------
    assign card_io_out = 1'b0;

    // After the third deactivation step the line is held low.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            card_io_oe_n <= 1'b1;
        end else if (clk_en) begin
            if (state_r == SCPS_DEACT) begin
                card_io_oe_n <= !(step_r == DEACT_LAST || (step_r == 2'h2 && ck_rise));
            end else begin
                card_io_oe_n <= tx_busy_r ? tx_sh_r[0] : 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_clk_toggle_half:
    assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && div_hit) |=> (card_clock_out != $past(card_clock_out)))
    else $error("card clock did not toggle at half period");

    a_clk_needs_supply:
    assert property (@(posedge sys_clk) disable iff (rst)
        card_clock_out |-> card_supply_enable)
    else $error("card clock running without supply");

    a_rst_low_hold:
    assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && $past(clk_en) && $rose(card_reset_line) && low_reset_card)
        |-> $past(cyc_cnt_r) >= RST_LOW_C)
    else $error("reset released before hold time");

    a_rst_high_session:
    assert property (@(posedge sys_clk) disable iff (rst)
        session_active |-> card_reset_line || !low_reset_card)
    else $error("reset low during session");

    a_timeout_flag_set:
    assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && in_window && cyc_cnt_r > ATR_MAX_C) |=> answer_timeout)
    else $error("answer timeout not flagged");

    a_removal_flag_set:
    assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && pd_fall) |=> removal_flag)
    else $error("removal not reported");

    a_deact_order:
    assert property (@(posedge sys_clk) disable iff (rst)
        $fell(card_supply_enable) |-> !card_clock_out && !card_reset_line && !card_io_oe_n)
    else $error("supply dropped out of order");

    a_deact_slow_step:
    assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == SCPS_DEACT && $changed(step_r)) |-> $past(ck_rise))
    else $error("deactivation step without slow clock edge");

    a_removal_deact:
    assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && pd_fall && state_r == SCPS_SESS) |=> state_r == SCPS_DEACT)
    else $error("removal did not start deactivation");
endmodule

/* File: scps_pkg.sv */
package scps_pkg;

    // ----------------------------------------------------------------
    // System clock and card clock range
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ = 40_000_000; // Sequencer clock rate.
    localparam int CARD_CLK_MIN_HZ = 10_000; // Slowest card clock, 0.01 MHz.
    localparam int CARD_CLK_MAX_HZ = 25_000_000; // Fastest card clock, 25 MHz.
    // Longest half period rounds down, shortest rounds up, never below one.
    localparam int HALF_MAX_CYC = SYS_CLK_HZ / (2 * CARD_CLK_MIN_HZ);
    localparam int HALF_MIN_RAW = (SYS_CLK_HZ + 2 * CARD_CLK_MAX_HZ - 1) / (2 * CARD_CLK_MAX_HZ);
    localparam int HALF_MIN_CYC = (HALF_MIN_RAW < 1) ? 1 : HALF_MIN_RAW;

    // ----------------------------------------------------------------
    // Bit rate ratios and activation counts, in card clock cycles
    // ----------------------------------------------------------------
    localparam int RATIO_DEF = 372; // Usual card clocks per bit.
    localparam int RATIO_MIN = 16; // Lowest supported card clocks per bit.
    localparam int ATR_MIN_CLKS = 400; // Earliest legal answer start.
    localparam int ATR_MAX_CLKS = 40000; // Latest legal answer start.
    localparam int RST_LOW_CLKS = 40000; // Least reset low time after T0.

    // ----------------------------------------------------------------
    // Character framing
    // ----------------------------------------------------------------
    localparam int CHAR_DATA_BITS = 8; // Data bits per character.
    localparam logic [3:0] RX_LAST_BIT = 4'h9; // Start, eight data, parity.
    localparam logic [3:0] TX_LAST_BIT = 4'hb; // Plus two guard bits.
    localparam logic [1:0] DEACT_LAST = 2'h3; // Final deactivation step.

    // ----------------------------------------------------------------
    // Sequencer states, Gray coded along the activation path through the reset pulse
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SCPS_OFF = 3'h0,
        SCPS_PWR = 3'h1,
        SCPS_RSTLO = 3'h3,
        SCPS_ANS = 3'h2,
        SCPS_SESS = 3'h6,
        SCPS_DEACT = 3'h7
    } scps_state_e;

endpackage

/* File: scps_card_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Card model
// ----------------------------------------------------------------
module scps_card_model (
    // Device pins.
    input wire logic card_clock_out,
    input wire logic card_reset_line,
    input wire logic card_io_oe_n,
    // Answer setup.
    input wire logic ans_en,
    input wire logic [7:0] ans_byte,
    // Resolved line.
    output logic io_line
);
    int cnt = 0; // Card clocks since reset went high.
    logic [9:0] frm; // Start, data, even parity.
    logic bt; // Level the card drives.
    // Counting restarts at T0 or T1; a held reset keeps the card quiet.
    always @(posedge card_clock_out or negedge card_reset_line) begin
        if (!card_reset_line) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Line high by 200 clocks, answer at 420 clocks, 16 clocks a bit.
    always_comb begin
        frm = {^ans_byte, ans_byte, 1'b0};
        bt = 1'b1;
        if (ans_en && cnt >= 420 && cnt < 580) begin
            bt = frm[(cnt - 420) / 16];
        end
    end
    // Pull-up: either side may pull the line low.
    assign io_line = bt & card_io_oe_n;
endmodule

/* File: test_smart_card_port_sequencer.sv */
`timescale 1ns/100ps
`define CHK(n, a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
`define WT(c) n = 0; while (!(c) && n < 5000) begin @(negedge sys_clk); n++; end
module test_smart_card_port_sequencer;
    logic sys_clk = 0, rst = 1, act = 0, dq = 0, lowr = 0, fclr = 0, txv = 0, pd = 1, slow = 0;
    logic ans_en = 1, ce = 1;
    logic sa, busy, ato, ae, rem, txr, rxv, perr, cclk, crst, csup, io_o, oe_n, io;
    logic [7:0] txd = 0, ab = 0, rxd;
    logic [7:0] exp_q[$]; // Expected answer bytes.
    int mismatches = 0, tests_run = 0, cyc = 0, n, seed = 32'ha38b5d00;
    // Clocks; the slow reference runs free at 200 ns.
    initial forever #12.5 sys_clk = ~sys_clk;
    initial forever #100 slow = ~slow;
    scps_port #(.ATR_MAX(500), .RST_LOW(600)) DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(ce),
        .activate_req(act), .deactivate_req(dq), .low_reset_card(lowr),
        .clk_half_cycles(16'h0001), .clks_per_bit(16'h0010), .flags_clr(fclr),
        .session_active(sa), .seq_busy(busy), .answer_timeout(ato), .answer_early(ae),
        .removal_flag(rem), .tx_valid(txv), .tx_ready(txr), .tx_data(txd), .rx_valid(rxv),
        .rx_data(rxd), .rx_parity_err(perr), .card_clock_out(cclk), .card_reset_line(crst),
        .card_supply_enable(csup), .card_io_in(io), .card_io_out(io_o), .card_io_oe_n(oe_n),
        .card_presence_detect(pd), .slow_reference_clock(slow));
    scps_card_model card (.card_clock_out(cclk), .card_reset_line(crst), .card_io_oe_n(oe_n),
        .ans_en(ans_en), .ans_byte(ab), .io_line(io));
    // Print counts and verdict, then stop.
    task conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Start a session; the answer byte is noted before it can arrive.
    task activate(input logic low, input logic en);
        lowr = low;
        ans_en = en;
        ab = $random(seed);
        if (en) begin
            exp_q.push_back(ab);
        end
        act = 1;
        @(negedge sys_clk);
        act = 0;
    endtask
    // Step order: reset, clock, line, supply, one slow period each.
    task down();
        `WT(crst === 1'b0)
        `WT(oe_n === 1'b0)
        `CHK("clock stop", cclk, 1'b0)
        `CHK("supply held", csup, 1'b1)
        `WT(csup === 1'b0)
        `CHK("step gap", n >= 7 && n <= 9, 1'b1)
        `CHK("idle", busy, 1'b0)
    endtask
    // Watchdog and receive scoreboard, sampling between clock edges.
    always @(negedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
        if (rxv) begin
            `CHK("rx_data", rxd, exp_q.pop_front())
            `CHK("parity", perr, 1'b0)
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 0;
        // Fill the buffer outside a session until it refuses.
        n = 0;
        txv = 1;
        while (txr === 1'b1) begin
            txd = $random(seed);
            @(negedge sys_clk);
            n++;
        end
        txv = 0;
        `CHK("fifo depth", n, 16)
        activate(0, 1);
        `WT(sa === 1'b1)
        `CHK("session", sa, 1'b1)
        `WT(rxv === 1'b1)
        `CHK("answer", rxv, 1'b1)
        `CHK("early", ae, 1'b0)
        dq = 1;
        @(negedge sys_clk);
        dq = 0;
        down();
        // Reset held low for the full count, answer after T1.
        activate(1, 1);
        n = 0;
        while (crst !== 1'b1 && n < 9000) begin
            @(posedge cclk);
            n++;
        end
        `CHK("reset low", n >= 600, 1'b1)
        `WT(sa === 1'b1)
        `CHK("session", sa, 1'b1)
        `WT(rxv === 1'b1)
        `CHK("answer", rxv, 1'b1)
        `CHK("early", ae, 1'b0)
        // Removal deactivates and is reported.
        pd = 0;
        down();
        `CHK("removal", rem, 1'b1)
        pd = 1;
        fclr = 1;
        repeat (4) @(negedge sys_clk);
        fclr = 0;
        `CHK("removal clear", rem, 1'b0)
        // A silent card runs out its window; a frozen enable halts the clock meanwhile.
        activate(0, 0);
        `WT(cclk === 1'b1)
        ce = 0;
        repeat (21) @(negedge sys_clk);
        `CHK("frozen", cclk, 1'b1)
        ce = 1;
        `WT(ato === 1'b1)
        `CHK("timeout", ato, 1'b1)
        `CHK("answers left", exp_q.size(), 0)
        conclude();
    end
endmodule
